// ### dma_cfg.svh
// constants for the dual-buffer serial dma ends
// assumes: included by bare name from the package only; both ends see it through the package file
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
// ==========================================
// device register indices on the link
`define RG_RXA_ADDR 5'h00
`define RG_RXA_CNT 5'h01
`define RG_RXA_STS 5'h02
`define RG_RXB_ADDR 5'h03
`define RG_RXB_CNT 5'h04
`define RG_RXB_STS 5'h05
`define RG_TXA_ADDR 5'h06
`define RG_TXA_CNT 5'h07
`define RG_TXA_STS 5'h08
`define RG_TXB_ADDR 5'h09
`define RG_TXB_CNT 5'h0A
`define RG_TXB_STS 5'h0B
`define RG_BSTS 5'h0C
`define RG_IRQ_EN 5'h0D
`define RG_RISR 5'h0E
`define RG_TX_IRQ_STS 5'h0F
`define RG_RXCUR 5'h10
`define RG_TX_CMD 5'h11
// ==========================================
// descriptor status bits
`define B_OWN 0
`define B_IRQ_SEL 1
`define B_APPEND 3
`define B_BUF_START 4
`define B_BUF_END 5
`define B_EOF 6
`define B_ERR 7
// dma_buffer_status bits
`define S_RBUSY 0
`define S_NRBUF 1
`define S_TBUSY 2
`define S_NTBUF 3
// interrupt_enable_reg, tx_interrupt_status, special_tx_command bits
`define IE_TXD 0
`define IE_TX_EMPTY 1
`define IE_RX 2
`define TI_TXD 0
`define ST_APPEND_END 0
// ==========================================
// host apb map and memory
`define H_ADDR 12'h000
`define H_WDATA 12'h004
`define H_CTRL 12'h008
`define H_STAT 12'h00C
`define H_RDATA 12'h010
`define H_MEM_LO 12'h100
`define H_MEM_HI 12'h1FC
`define C_GO 0
`define C_WE 1
`define MEM_AW 6
`define CNT_ONE 16'h0001
`endif

// ### dma_pkg.sv
// types shared by both ends of the dma link
// assumes: dma_cfg.svh on the include path
`include "dma_cfg.svh"
package dma_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] cnt;
		logic [7:0] sts;
	} desc_s;
	typedef enum logic [1:0] {RX_IDLE, RX_WRITE} rx_state_e;
	typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} tx_state_e;
	typedef struct packed {
		rx_state_e st;
		logic sel, nxt, busy, first, last, good, req, done, dbuf, rdy;
		logic [15:0] cnt, dcnt;
		logic [7:0] data, dsts;
		logic [31:0] maddr;
	} rx_s;
	typedef struct packed {
		desc_s rxa, rxb, txa, txb;
		logic [7:0] irq_en, risr, tx_irq_sts, tdata;
		logic ntbuf, tbusy, cur, aterm, ack, tmreq, tvalid, tlast, rxirq, txirq;
		tx_state_e tst;
		logic [15:0] idx, asent;
		logic [31:0] taddr, rdata;
	} dev_s;
	typedef struct packed {
		logic [(1<<`MEM_AW)-1:0][7:0] mem;
		logic [4:0] addr;
		logic [31:0] wdata, rdata, prdata;
		logic we, req, pready, pslverr, rmack, tmack;
		logic [7:0] tmdata;
	} host_s;
endpackage

// ### dma_link.sv
// link between the host end and the device end
// assumes: both ends on one clock; every request held until its ack
interface dma_link;
	logic reg_req, reg_we, reg_ack;
	logic [4:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic rmem_req, rmem_ack;
	logic [31:0] rmem_addr;
	logic [7:0] rmem_data;
	logic tmem_req, tmem_ack;
	logic [31:0] tmem_addr;
	logic [7:0] tmem_data;
	logic rx_irq, tx_irq;
	modport dev(input reg_req, reg_we, reg_addr, reg_wdata, rmem_ack, tmem_ack, tmem_data,
		output reg_ack, reg_rdata, rmem_req, rmem_addr, rmem_data, tmem_req, tmem_addr, rx_irq, tx_irq);
	modport host(output reg_req, reg_we, reg_addr, reg_wdata, rmem_ack, tmem_ack, tmem_data,
		input reg_ack, reg_rdata, rmem_req, rmem_addr, rmem_data, tmem_req, tmem_addr, rx_irq, tx_irq);
endinterface

// ### rx_dma_engine.sv
// receive side of one channel: stores bytes into buffer a or b
// assumes: descriptors come from the owning register file, same clock
module rx_dma_engine
	import dma_pkg::*;
(
	input logic clk_i,
	input logic rst_n_i,
	input logic ce_i,
	input dma_pkg::desc_s da_i,
	input dma_pkg::desc_s db_i,
	input logic rx_valid_i,
	input logic [7:0] rx_data_i,
	input logic rx_last_i,
	input logic rx_good_i,
	input logic mem_ack_i,
	output dma_pkg::rx_s st_o
);
	rx_s q, n;
	desc_s d;

	always_comb begin
		n = q;
		d = q.sel ? db_i : da_i;
		n.done = 1'b0;
		case (q.st)
			RX_IDLE: begin
				if (rx_valid_i && q.rdy) begin
					if (q.cnt == '0) begin
						n.nxt = ~q.sel;
					end
					if (!q.busy) begin
						n.busy = 1'b1;
						n.first = 1'b1;
					end
					n.data = rx_data_i;
					n.last = rx_last_i;
					n.good = rx_good_i;
					n.req = 1'b1;
					n.st = RX_WRITE;
				end
			end
			RX_WRITE: begin
				if (mem_ack_i) begin
					n.req = 1'b0;
					n.cnt = q.cnt + `CNT_ONE;
					n.st = RX_IDLE;
					if (q.last || n.cnt == d.cnt) begin
						n.done = 1'b1;
						n.dbuf = q.sel;
						n.dcnt = n.cnt;
						n.dsts = '0;
						n.dsts[`B_BUF_END] = 1'b1;
						n.dsts[`B_EOF] = q.last && q.good;
						n.dsts[`B_ERR] = q.last && !q.good;
						n.dsts[`B_BUF_START] = !q.last && q.first;
						n.first = 1'b0;
						n.cnt = '0;
						n.sel = ~q.sel;
						if (q.last) begin
							n.busy = 1'b0;
						end
					end
				end
			end
			default: n.st = RX_IDLE;
		endcase
		// flags registered so the user side sees flop outputs
		n.rdy = (n.st == RX_IDLE) && !n.done && (n.sel ? db_i.sts[`B_OWN] : da_i.sts[`B_OWN]);
		n.maddr = (n.sel ? db_i.addr : da_i.addr) + {16'h0000, n.cnt};
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= n;
		end
	end

	assign st_o = q;
endmodule

// ### dma_device.sv
// device end: dual descriptor dma for one channel, receive and transmit
// assumes: host end serves memory requests; tx consumer is a fifo on tx_ready_i
// Operation
// - frame start flips next receive buffer flag
// - receive busy set during frame, cleared after
// - receive pointer advances per stored byte
// - check delimiter and crc before completing
// - frame end writes actual count back
// - last buffer: end flags set, ownership cleared
// - first full link: end, start flags, count kept
// - receive status: frame end bit6, buffer end bit5
// - host supplies next buffer within one buffer
// - host writes address, count, then ownership
// - two tx descriptors: address, count, status
// - owned descriptor not written by host
// - transmit a then b, alternating on ownership
// - next transmit buffer flag tracks next descriptor
// - empty interrupt when nothing to send
// - done interrupt once per buffer end
// - per descriptor interrupt select bit1
// - chain buffers until eof, then crc
// - append mode scans a count for growth
// - idle append serves owned b, then resumes
// - host writes append count as a word
// - command ends append after queued data
// - next transmit flag bit3, cleared starting b
//
// The APB slave port and the address map were chosen for this implementation.
module dma_device
	import dma_pkg::*;
(
	input logic clk_i,
	input logic rst_n_i,
	input logic ce_i,
	dma_link.dev lnk,
	input logic chan_en_i,
	input logic dma_sel_i,
	input logic sync_i,
	input logic rx_valid_i,
	input logic [7:0] rx_data_i,
	input logic rx_last_i,
	input logic rx_good_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input logic tx_ready_i
);
	dev_s q, n;
	rx_s rx;
	desc_s d;
	logic en, ta, avail, fin_now;

	// descriptors and flags are per instance, one instance per channel
	rx_dma_engine u_rx (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.da_i(q.rxa),
		.db_i(q.rxb),
		.rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i),
		.rx_last_i(rx_last_i),
		.rx_good_i(rx_good_i),
		.mem_ack_i(lnk.rmem_ack),
		.st_o(rx)
	);

	function automatic logic [7:0] finish(input logic [7:0] s);
		logic [7:0] r;
		r = s;
		r[`B_OWN] = 1'b0;
		r[`B_BUF_END] = 1'b1;
		return r;
	endfunction

	function automatic logic [7:0] tupd(input logic [7:0] t, input logic [7:0] s);
		logic [7:0] r;
		r = t;
		r[`B_BUF_END] = 1'b1;
		r[`B_EOF] = s[`B_EOF];
		r[`TI_TXD] = t[`TI_TXD] | s[`B_IRQ_SEL];
		return r;
	endfunction

	always_comb begin
		n = q;
		fin_now = 1'b0;
		en = chan_en_i && dma_sel_i;
		ta = q.txa.sts[`B_OWN] && q.txa.sts[`B_APPEND];
		d = q.cur ? q.txb : q.txa;
		n.ack = 1'b0;
		// ==========================================
		// register port
		if (lnk.reg_req && !q.ack) begin
			n.ack = 1'b1;
			case (lnk.reg_addr)
				`RG_RXA_ADDR: n.rdata = q.rxa.addr;
				`RG_RXA_CNT: n.rdata = {16'h0000, q.rxa.cnt};
				`RG_RXA_STS: n.rdata = {24'h000000, q.rxa.sts};
				`RG_RXB_ADDR: n.rdata = q.rxb.addr;
				`RG_RXB_CNT: n.rdata = {16'h0000, q.rxb.cnt};
				`RG_RXB_STS: n.rdata = {24'h000000, q.rxb.sts};
				`RG_TXA_ADDR: n.rdata = q.txa.addr;
				`RG_TXA_CNT: n.rdata = {16'h0000, q.txa.cnt};
				`RG_TXA_STS: n.rdata = {24'h000000, q.txa.sts};
				`RG_TXB_ADDR: n.rdata = q.txb.addr;
				`RG_TXB_CNT: n.rdata = {16'h0000, q.txb.cnt};
				`RG_TXB_STS: n.rdata = {24'h000000, q.txb.sts};
				`RG_BSTS: n.rdata = {28'h0000000, q.ntbuf, q.tbusy, rx.nxt, rx.busy};
				`RG_IRQ_EN: n.rdata = {24'h000000, q.irq_en};
				`RG_RISR: n.rdata = {24'h000000, q.risr};
				`RG_TX_IRQ_STS: n.rdata = {24'h000000, q.tx_irq_sts};
				`RG_RXCUR: n.rdata = rx.maddr;
				default: n.rdata = '0;
			endcase
			if (lnk.reg_we) begin
				// address and count locked while the device owns the descriptor, except txa count in append mode
				case (lnk.reg_addr)
					`RG_RXA_ADDR: if (!q.rxa.sts[`B_OWN]) n.rxa.addr = lnk.reg_wdata;
					`RG_RXA_CNT: if (!q.rxa.sts[`B_OWN]) n.rxa.cnt = lnk.reg_wdata[15:0];
					`RG_RXA_STS: n.rxa.sts = lnk.reg_wdata[7:0];
					`RG_RXB_ADDR: if (!q.rxb.sts[`B_OWN]) n.rxb.addr = lnk.reg_wdata;
					`RG_RXB_CNT: if (!q.rxb.sts[`B_OWN]) n.rxb.cnt = lnk.reg_wdata[15:0];
					`RG_RXB_STS: n.rxb.sts = lnk.reg_wdata[7:0];
					`RG_TXA_ADDR: if (!q.txa.sts[`B_OWN]) n.txa.addr = lnk.reg_wdata;
					`RG_TXA_CNT: if (!q.txa.sts[`B_OWN] || ta) n.txa.cnt = lnk.reg_wdata[15:0];
					`RG_TXA_STS: n.txa.sts = lnk.reg_wdata[7:0];
					`RG_TXB_ADDR: if (!q.txb.sts[`B_OWN]) n.txb.addr = lnk.reg_wdata;
					`RG_TXB_CNT: if (!q.txb.sts[`B_OWN]) n.txb.cnt = lnk.reg_wdata[15:0];
					`RG_TXB_STS: n.txb.sts = lnk.reg_wdata[7:0];
					`RG_IRQ_EN: n.irq_en = lnk.reg_wdata[7:0];
					`RG_RISR: n.risr = q.risr & ~lnk.reg_wdata[7:0];
					`RG_TX_IRQ_STS: n.tx_irq_sts = q.tx_irq_sts & ~lnk.reg_wdata[7:0];
					`RG_TX_CMD: if (lnk.reg_wdata[`ST_APPEND_END]) n.aterm = 1'b1;
					default: n.irq_en = n.irq_en;
				endcase
			end
		end
		// ==========================================
		// receive write-back, after host writes so hardware set wins
		if (rx.done) begin
			if (rx.dbuf) begin
				n.rxb.cnt = rx.dcnt;
				n.rxb.sts = rx.dsts;
			end else begin
				n.rxa.cnt = rx.dcnt;
				n.rxa.sts = rx.dsts;
			end
			n.risr[`B_BUF_END] = 1'b1;
			n.risr[`B_EOF] = rx.dsts[`B_EOF];
		end
		// ==========================================
		// transmit engine
		case (q.tst)
			TX_IDLE: begin
				if (en) begin
					if (ta && !q.cur) begin
						if (q.txa.cnt != q.asent) begin
							n.idx = q.asent;
							n.tst = TX_FETCH;
							n.tmreq = 1'b1;
							n.tbusy = 1'b1;
						end else if (q.aterm) begin
							n.txa.sts = finish(n.txa.sts);
							n.tx_irq_sts = tupd(n.tx_irq_sts, q.txa.sts);
							n.aterm = 1'b0;
							n.asent = '0;
						end else if (q.txb.sts[`B_OWN]) begin
							n.cur = 1'b1;
						end
					end else if (d.sts[`B_OWN]) begin
						n.ntbuf = ~q.cur;
						n.idx = '0;
						n.tbusy = 1'b1;
						if (d.cnt == '0) begin
							fin_now = 1'b1;
						end else begin
							n.tst = TX_FETCH;
							n.tmreq = 1'b1;
						end
					end
				end
			end
			TX_FETCH: begin
				if (lnk.tmem_ack) begin
					n.tmreq = 1'b0;
					n.tdata = lnk.tmem_data;
					n.tvalid = 1'b1;
					// crc only after the last byte of the eof buffer
					n.tlast = !(ta && !q.cur) && (q.idx + `CNT_ONE == d.cnt) && d.sts[`B_EOF] && sync_i;
					n.tst = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tx_ready_i) begin
					n.tvalid = 1'b0;
					n.tlast = 1'b0;
					if (ta && !q.cur) begin
						n.asent = q.idx + `CNT_ONE;
						n.tbusy = 1'b0;
						n.tst = TX_IDLE;
					end else if (q.idx + `CNT_ONE == d.cnt) begin
						fin_now = 1'b1;
					end else begin
						n.idx = q.idx + `CNT_ONE;
						n.tmreq = 1'b1;
						n.tst = TX_FETCH;
					end
				end
			end
			default: n.tst = TX_IDLE;
		endcase
		if (fin_now) begin
			if (q.cur) begin
				n.txb.sts = finish(n.txb.sts);
			end else begin
				n.txa.sts = finish(n.txa.sts);
			end
			n.tx_irq_sts = tupd(n.tx_irq_sts, d.sts);
			n.cur = ~q.cur;
			n.tbusy = 1'b0;
			n.tst = TX_IDLE;
		end
		n.taddr = (n.cur ? n.txb.addr : n.txa.addr) + {16'h0000, n.idx};
		// ==========================================
		// interrupt levels
		avail = (ta && !q.cur) ? (q.txa.cnt != q.asent || q.txb.sts[`B_OWN]) : d.sts[`B_OWN];
		n.txirq = (n.irq_en[`IE_TXD] && n.tx_irq_sts[`TI_TXD]) ||
			(n.irq_en[`IE_TX_EMPTY] && en && q.tst == TX_IDLE && !avail);
		n.rxirq = n.irq_en[`IE_RX] && (n.risr[`B_BUF_END] || n.risr[`B_EOF]);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= n;
		end
	end

	assign lnk.reg_ack = q.ack;
	assign lnk.reg_rdata = q.rdata;
	assign lnk.rmem_req = rx.req;
	assign lnk.rmem_addr = rx.maddr;
	assign lnk.rmem_data = rx.data;
	assign lnk.tmem_req = q.tmreq;
	assign lnk.tmem_addr = q.taddr;
	assign lnk.rx_irq = q.rxirq;
	assign lnk.tx_irq = q.txirq;
	assign rx_ready_o = rx.rdy;
	assign tx_valid_o = q.tvalid;
	assign tx_data_o = q.tdata;
	assign tx_last_o = q.tlast;
endmodule

// ### dma_host.sv
// host end: apb bridge to device registers plus buffer memory
// assumes: software drives apb on clk_i; device holds requests until ack
module dma_host
	import dma_pkg::*;
(
	input logic clk_i,
	input logic rst_n_i,
	input logic ce_i,
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [11:0] paddr_i,
	input logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	dma_link.host lnk
);
	host_s q, n;
	logic inmem;

	always_comb begin
		n = q;
		inmem = paddr_i >= `H_MEM_LO && paddr_i <= `H_MEM_HI;
		// ==========================================
		// apb: setup cycle prepares answer, access edge commits
		if (psel_i && !penable_i) begin
			n.pready = 1'b1;
			n.pslverr = 1'b0;
			n.prdata = '0;
			if (inmem) begin
				n.prdata = {24'h000000, q.mem[paddr_i[`MEM_AW+1:2]]};
			end else begin
				case (paddr_i)
					`H_ADDR: n.prdata = {27'h0, q.addr};
					`H_WDATA: n.prdata = q.wdata;
					`H_CTRL: n.prdata = {30'h0, q.we, q.req};
					`H_STAT: n.prdata = {29'h0, lnk.tx_irq, lnk.rx_irq, q.req};
					`H_RDATA: n.prdata = q.rdata;
					default: n.pslverr = 1'b1;
				endcase
			end
		end else if (psel_i && penable_i && q.pready) begin
			n.pready = 1'b0;
			n.pslverr = 1'b0;
			if (pwrite_i && inmem) begin
				n.mem[paddr_i[`MEM_AW+1:2]] = pwdata_i[7:0];
			end else if (pwrite_i) begin
				case (paddr_i)
					`H_ADDR: n.addr = pwdata_i[4:0];
					`H_WDATA: n.wdata = pwdata_i;
					`H_CTRL: begin
						// one whole word per register, in software order
						if (pwdata_i[`C_GO] && !q.req) begin
							n.req = 1'b1;
							n.we = pwdata_i[`C_WE];
						end
					end
					default: n.wdata = q.wdata;
				endcase
			end
		end
		// ==========================================
		// device register command
		if (q.req && lnk.reg_ack) begin
			n.req = 1'b0;
			n.rdata = lnk.reg_rdata;
		end
		// ==========================================
		// buffer memory: one cycle answers keep the device ahead of overrun
		n.rmack = lnk.rmem_req && !q.rmack;
		if (n.rmack) begin
			n.mem[lnk.rmem_addr[`MEM_AW-1:0]] = lnk.rmem_data;
		end
		n.tmack = lnk.tmem_req && !q.tmack;
		if (n.tmack) begin
			n.tmdata = q.mem[lnk.tmem_addr[`MEM_AW-1:0]];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= n;
		end
	end

	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign lnk.reg_req = q.req;
	assign lnk.reg_we = q.we;
	assign lnk.reg_addr = q.addr;
	assign lnk.reg_wdata = q.wdata;
	assign lnk.rmem_ack = q.rmack;
	assign lnk.tmem_ack = q.tmack;
	assign lnk.tmem_data = q.tmdata;
endmodule

// ### dma_assertions.sv
// link checker: handshakes between the host end and the device end
// assumes: tb instantiates it beside the link; one clock domain
module dma_assertions (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reg_req,
	input wire logic reg_ack,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic rmem_req,
	input wire logic rmem_ack,
	input wire logic [31:0] rmem_addr,
	input wire logic [7:0] rmem_data,
	input wire logic tmem_req,
	input wire logic tmem_ack,
	input wire logic [31:0] tmem_addr,
	input wire logic rx_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// register port
	property p_reg_ack;
		reg_req && !reg_ack |=> reg_ack;
	endproperty
	a_reg_ack: assert property (p_reg_ack) else $error("register ack not one cycle after request");
	property p_reg_pulse;
		reg_ack |=> !reg_ack && !reg_req;
	endproperty
	a_reg_pulse: assert property (p_reg_pulse) else $error("register ack or request lingers");
	property p_reg_hold;
		reg_req && !reg_ack |=> $stable(reg_addr) && $stable(reg_wdata);
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("register request changed while waiting");
	// ==========================================
	// receive memory writes: one byte per held request
	property p_rmem_ack;
		$rose(rmem_req) |-> ##1 rmem_ack;
	endproperty
	a_rmem_ack: assert property (p_rmem_ack) else $error("receive write not acked in time");
	property p_rmem_hold;
		rmem_req && !rmem_ack |=> rmem_req && $stable(rmem_addr) && $stable(rmem_data);
	endproperty
	a_rmem_hold: assert property (p_rmem_hold) else $error("receive write dropped or changed early");
	property p_rmem_drop;
		rmem_ack |-> ##1 !rmem_req;
	endproperty
	a_rmem_drop: assert property (p_rmem_drop) else $error("receive write held past ack");
	// ==========================================
	// transmit memory reads
	property p_tmem_ack;
		tmem_req && !tmem_ack |=> tmem_ack && tmem_req && $stable(tmem_addr);
	endproperty
	a_tmem_ack: assert property (p_tmem_ack) else $error("transmit fetch not answered in one cycle");
	property p_tmem_drop;
		tmem_ack |=> !tmem_req;
	endproperty
	a_tmem_drop: assert property (p_tmem_drop) else $error("transmit fetch held past ack");
	c_rx: cover property (rmem_ack);
	c_tx: cover property (tmem_ack ##1 !tmem_req);
	c_irq: cover property ($rose(rx_irq));
endmodule

// ### tb.sv
// self-checking bench: apb software, receive stream, transmit sink
// assumes: dma_pkg, dma_link and both ends compiled before it
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dma_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic en = 1'b0;
	logic sync = 1'b0;
	logic rx_valid = 1'b0;
	logic rx_last = 1'b0;
	logic rx_good = 1'b0;
	logic tx_ready = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] rx_data = 8'h00;
	logic [7:0] seed = 8'h20;
	logic [7:0] st = 8'h20;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serr, rx_ready, tx_valid, tx_last;
	logic [7:0] tx_data;
	logic [7:0] ex[$], txq[$];
	logic lastq[$];
	int fail_count = 0;
	int comparisons = 0;
	dma_link lnk();
	dma_host u_dma_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .lnk(lnk));
	dma_device u_dma_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .lnk(lnk), .chan_en_i(en),
		.dma_sel_i(en), .sync_i(sync), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last),
		.rx_good_i(rx_good), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.tx_last_o(tx_last), .tx_ready_i(tx_ready));
	dma_assertions u_dma_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req(lnk.reg_req),
		.reg_ack(lnk.reg_ack), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .rmem_req(lnk.rmem_req),
		.rmem_ack(lnk.rmem_ack), .rmem_addr(lnk.rmem_addr), .rmem_data(lnk.rmem_data),
		.tmem_req(lnk.tmem_req), .tmem_ack(lnk.tmem_ack), .tmem_addr(lnk.tmem_addr), .rx_irq(lnk.rx_irq));
	// ==========================================
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tmo;
		fail_count++;
		$display("[ERR] wait expected done seen timeout");
		finish_test();
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// apb master: hold until pready seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (pready === 1'b1) break;
		end
		if (k == 20) tmo();
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	// one link command through the bridge, polled until not busy
	task automatic dev(input logic w, input logic [4:0] i, input logic [31:0] d);
		int k;
		apb(1'b1, `H_ADDR, {27'h0, i});
		apb(1'b1, `H_WDATA, d);
		apb(1'b1, `H_CTRL, {30'h0, w, 1'b1});
		for (k = 0; k < 20; k++) begin
			apb(1'b0, `H_STAT, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (k == 20) tmo();
		apb(1'b0, `H_RDATA, 32'h0);
	endtask
	task automatic wr(input logic [4:0] i, input logic [31:0] d);
		dev(1'b1, i, d);
	endtask
	task automatic rdr(input logic [4:0] i);
		dev(1'b0, i, 32'h0);
	endtask
	// address and count first, ownership last
	task automatic desc(input logic [4:0] i, input logic [31:0] a, input logic [31:0] c, input logic [31:0] s);
		wr(i, a);
		wr(5'(i + 1), c);
		wr(5'(i + 2), s);
	endtask
	task automatic wait0(input logic [4:0] i);
		int k;
		for (k = 0; k < 40; k++) begin
			rdr(i);
			if (rd[0] === 1'b0) break;
		end
		if (k == 40) tmo();
	endtask
	task automatic waitq(input int n);
		int k;
		for (k = 0; k < 1000; k++) begin
			@(posedge clk_i);
			if (txq.size() >= n) break;
		end
		if (k == 1000) tmo();
	endtask
	task automatic rxb(input logic l, input logic g);
		int k;
		seed = lfsr(seed);
		ex.push_back(seed);
		rx_valid <= 1'b1;
		rx_data <= seed;
		rx_last <= l;
		rx_good <= g;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (rx_ready === 1'b1) break;
		end
		if (k == 50) tmo();
		rx_valid <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic frm(input int n, input logic g);
		for (int j = 0; j < n; j++) rxb(j == n - 1, g);
	endtask
	task automatic mchk(input int s, input int n);
		for (int j = 0; j < n; j++) begin
			apb(1'b0, `H_MEM_LO + 12'(4 * (s + j)), 32'h0);
			chk("mem", rd & 32'hFF, {24'h0, ex.pop_front()});
		end
	endtask
	task automatic fill(input int s, input int n);
		for (int j = 0; j < n; j++) begin
			seed = lfsr(seed);
			ex.push_back(seed);
			apb(1'b1, `H_MEM_LO + 12'(4 * (s + j)), {24'h0, seed});
		end
	endtask
	// transmit sink stalls at random
	always @(posedge clk_i) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			txq.push_back(tx_data);
			lastq.push_back(tx_last);
		end
		st <= lfsr(st);
		tx_ready <= st[0] | st[2];
	end
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rdr(`RG_BSTS);
		chk("bsts_reset", rd, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("pslverr", {31'h0, serr}, 32'h1);
		wr(`RG_TXB_ADDR, 32'hA55A0FF0);
		rdr(`RG_TXB_ADDR);
		chk("txb_addr", rd, 32'hA55A0FF0);
		wr(`RG_TXB_CNT, 32'h00011234);
		rdr(`RG_TXB_CNT);
		chk("txb_cnt", rd, 32'h00001234);
		$display("test registers done");
		wr(`RG_IRQ_EN, 32'h5);
		desc(`RG_RXA_ADDR, 32'h0, 32'h8, 32'h1);
		wr(`RG_RXA_ADDR, 32'h14);
		rdr(`RG_RXA_ADDR);
		chk("rxa_addr_owned", rd, 32'h0);
		rxb(1'b0, 1'b1);
		rdr(`RG_BSTS);
		chk("bsts_busy", rd & 32'h3, 32'h3);
		rdr(`RG_RXCUR);
		chk("rx_cur", rd, 32'h1);
		frm(4, 1'b1);
		wait0(`RG_RXA_STS);
		rdr(`RG_BSTS);
		chk("bsts_idle", rd & 32'h1, 32'h0);
		rdr(`RG_RXA_CNT);
		chk("rxa_cnt", rd & 32'hFFFF, 32'h5);
		rdr(`RG_RXA_STS);
		chk("rxa_sts", rd & 32'hFF, 32'h60);
		rdr(`RG_RISR);
		chk("risr", rd & 32'h60, 32'h60);
		apb(1'b0, `H_STAT, 32'h0);
		chk("rx_irq", rd & 32'h2, 32'h2);
		mchk(0, 5);
		wr(`RG_RISR, 32'h60);
		$display("test rx_single done");
		desc(`RG_RXB_ADDR, 32'h10, 32'h4, 32'h1);
		desc(`RG_RXA_ADDR, 32'h20, 32'h8, 32'h1);
		frm(6, 1'b1);
		wait0(`RG_RXA_STS);
		rdr(`RG_RXB_STS);
		chk("rxb_sts", rd & 32'hFF, 32'h30);
		rdr(`RG_RXB_CNT);
		chk("rxb_cnt", rd & 32'hFFFF, 32'h4);
		rdr(`RG_RXA_CNT);
		chk("rxa_cnt2", rd & 32'hFFFF, 32'h2);
		mchk(16, 4);
		mchk(32, 2);
		desc(`RG_RXB_ADDR, 32'h10, 32'h4, 32'h1);
		frm(2, 1'b0);
		wait0(`RG_RXB_STS);
		rdr(`RG_RXB_STS);
		chk("rxb_bad", rd & 32'hE1, 32'hA0);
		ex.delete();
		$display("test rx_chain done");
		sync <= 1'b1;
		en <= 1'b1;
		fill(40, 5);
		desc(`RG_TXB_ADDR, 32'd43, 32'h2, 32'h41);
		desc(`RG_TXA_ADDR, 32'd40, 32'h3, 32'h03);
		waitq(5);
		wait0(`RG_TXB_STS);
		for (int i = 0; i < 5; i++) begin
			chk("tx_data", {24'h0, txq[i]}, {24'h0, ex[i]});
			chk("tx_last", {31'h0, lastq[i]}, {31'h0, i == 4});
		end
		rdr(`RG_TX_IRQ_STS);
		chk("tx_interrupt_status", rd & 32'h41, 32'h41);
		rdr(`RG_TXA_STS);
		chk("txa_sts", rd & 32'h21, 32'h20);
		rdr(`RG_BSTS);
		chk("ntbuf", rd & 32'h8, 32'h0);
		apb(1'b0, `H_STAT, 32'h0);
		chk("tx_irq", rd & 32'h4, 32'h4);
		wr(`RG_TX_IRQ_STS, 32'h61);
		apb(1'b0, `H_STAT, 32'h0);
		chk("tx_irq_clr", rd & 32'h4, 32'h0);
		wr(`RG_IRQ_EN, 32'h6);
		apb(1'b0, `H_STAT, 32'h0);
		chk("tx_empty", rd & 32'h4, 32'h4);
		wr(`RG_IRQ_EN, 32'h5);
		$display("test tx_chain done");
		sync <= 1'b0;
		ex.delete();
		txq.delete();
		lastq.delete();
		fill(50, 2);
		desc(`RG_TXA_ADDR, 32'd50, 32'h0, 32'h09);
		wr(`RG_TXA_CNT, 32'h2);
		waitq(2);
		fill(60, 1);
		desc(`RG_TXB_ADDR, 32'd60, 32'h1, 32'h01);
		waitq(3);
		fill(52, 1);
		wr(`RG_TXA_CNT, 32'h3);
		waitq(4);
		wr(`RG_TX_CMD, 32'h1);
		wait0(`RG_TXA_STS);
		for (int i = 0; i < 4; i++) chk("append", {24'h0, txq[i]}, {24'h0, ex[i]});
		chk("append_len", 32'(txq.size()), 32'h4);
		$display("test append done");
		finish_test();
	end
endmodule
